//--- hw/mis_irq_source.sv
// Interrupt request logic: pin, filtered pin, comparator, protection
// and two grouped sources, with an AXI4-Lite register port.
// Assumes the program sequencer acks only while a request is shown.
// Function
// - External pin flag sets on a transition of the selected edge type.
// - External vector needs global enable, own enable, flag, stack not full.
// - Servicing external request clears its flag and the global enable.
// - Edge select offers rising, falling, both, or detection off.
// - Filtered pin flag sets on the edge chosen by its two-bit field.
// - Filtered vector needs both enables; servicing clears flag and global enable.
// - Comparator flag sets on output edge chosen by its two-bit field.
// - Comparator vector needs both enables and room; servicing clears its flag.
// - Protection signal sets its flag; gated by enables; self-clears on service.
// - Group flag sets whenever any source of its group raises an event, enabled or not.
// - Grouped source vectors with global, group and source enables, room.
// - Group service clears group flag and global enable, not source flags.
// - Conversion done flag; limit flag on high and/or low bound condition.
// - Capture overflow and match flags are grouped, not cleared on service.
// - PWM period and three duty flags join the second group, own enables.
// - Requests raised while globally disabled stay latched until enabled.
`timescale 1ns/1ps
module mis_irq_source (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [4:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [4:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic EXT_PIN_I,
  input wire logic FILTERED_INPUT_PIN_I,
  input wire logic CMP_OUT_I,
  input wire logic MOTOR_PROTECT_SIGNAL_I,
  input wire logic CONV_DONE_I,
  input wire logic [11:0] CONV_RESULT_I,
  input wire logic CAPTURE_OVERFLOW_I,
  input wire logic CAPTURE_MATCH_I,
  input wire logic PWM_PERIOD_I,
  input wire logic [2:0] PWM_DUTY_I,
  input wire logic STACK_FULL_I,
  input wire logic VEC_ACK_I,
  output logic VEC_REQ_O,
  output logic [2:0] VEC_IDX_O,
  output logic IRQ_O
);

  // Reset release
  logic rst_a_r;
  logic rst_n;
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_a_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n <= rst_a_r;
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  logic [2:0] ext_s_r;
  logic [2:0] filt_s_r;
  logic ext_lvl_r;
  logic filt_lvl_r;
  logic cmp_lvl_r;
  logic ext_lvl_nxt;
  logic filt_lvl_nxt;
  assign ext_lvl_nxt = (ext_s_r[1] == ext_s_r[2]) ? ext_s_r[2] : ext_lvl_r;
  assign filt_lvl_nxt = (filt_s_r[1] == filt_s_r[2]) ? filt_s_r[2] : filt_lvl_r;
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ext_s_r <= 3'h0;
      filt_s_r <= 3'h0;
      ext_lvl_r <= 1'b0;
      filt_lvl_r <= 1'b0;
      cmp_lvl_r <= 1'b0;
    end else begin
      ext_s_r <= {ext_s_r[1:0], EXT_PIN_I};
      filt_s_r <= {filt_s_r[1:0], FILTERED_INPUT_PIN_I};
      ext_lvl_r <= ext_lvl_nxt;
      filt_lvl_r <= filt_lvl_nxt;
      cmp_lvl_r <= CMP_OUT_I;
    end
  end

  function automatic logic edge_hit(input mis_pkg::mis_edge_t sel, input logic old_v,
                                    input logic new_v);
    logic rise;
    logic fall;
    rise = new_v & ~old_v;
    fall = old_v & ~new_v;
    unique case (sel)
      mis_pkg::EDGE_OFF: edge_hit = 1'b0;
      mis_pkg::EDGE_RISE: edge_hit = rise;
      mis_pkg::EDGE_FALL: edge_hit = fall;
      mis_pkg::EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction : edge_hit

  // Registers
  localparam int NV = mis_pkg::NVEC;
  mis_pkg::mis_ctrl_t ctrl_r;
  logic [NV-1:0] vflag_r;
  logic [mis_pkg::NSRC-1:0] src_r;
  logic [31:0] srcen_r;
  logic [31:0] bound_r;
  logic [NV-1:0] stat_r;
  logic [NV-1:0] mask_r;

  // Source events
  logic ext_ev;
  logic filt_ev;
  logic cmp_ev;
  logic upper_hit;
  logic lower_hit;
  logic limit_ev;
  logic [mis_pkg::NSRC-1:0] src_ev;
  logic [NV-1:0] vset;
  logic [11:0] hi_bound;
  logic [11:0] lo_bound;
  assign ext_ev = edge_hit(ctrl_r.ext_pin_edge_select, ext_lvl_r, ext_lvl_nxt);
  assign filt_ev = edge_hit(ctrl_r.filtered_edge_sel, filt_lvl_r, filt_lvl_nxt);
  assign cmp_ev = edge_hit(ctrl_r.cmp_edge_sel, cmp_lvl_r, CMP_OUT_I);
  assign hi_bound = bound_r[11:0];
  assign lo_bound = bound_r[mis_pkg::POS_LOW_BOUND +: mis_pkg::RES_W];
  // Both bound enables set: either side of the window triggers
  assign upper_hit = srcen_r[mis_pkg::POS_UPPER_EN] & (CONV_RESULT_I > hi_bound);
  assign lower_hit = srcen_r[mis_pkg::POS_LOWER_EN] & (CONV_RESULT_I < lo_bound);
  assign limit_ev = CONV_DONE_I & (upper_hit | lower_hit);
  assign src_ev = {PWM_DUTY_I, PWM_PERIOD_I, CAPTURE_MATCH_I, CAPTURE_OVERFLOW_I,
                   limit_ev, CONV_DONE_I};
  assign vset = {|src_ev[7:4], |src_ev[3:0], MOTOR_PROTECT_SIGNAL_I, cmp_ev, filt_ev,
                 ext_ev};

  // Vector arbitration; flags stay latched while disabled
  logic [3:0] g0_mem;
  logic [3:0] g1_mem;
  logic [NV-1:0] ven;
  logic [NV-1:0] vpend;
  logic [NV-1:0] vgrant;
  logic any_pend;
  logic [2:0] pend_idx;
  assign g0_mem = src_r[3:0] & srcen_r[3:0];
  assign g1_mem = src_r[7:4] & srcen_r[7:4];
  assign ven = {ctrl_r.grp1_en & |g1_mem, ctrl_r.grp0_en & |g0_mem, ctrl_r.protect_req_en,
                ctrl_r.cmp_req_en, ctrl_r.filtered_req_en, ctrl_r.ext_pin_req_en};
  assign vpend = (ctrl_r.global_irq_en & ~STACK_FULL_I) ? (vflag_r & ven) : '0;
  assign any_pend = |vpend;
  always_comb begin
    pend_idx = 3'h0;
    for (int i = NV - 1; i >= 0; i--) begin
      if (vpend[i]) begin
        pend_idx = 3'(i);
      end
    end
  end
  assign vgrant = (VEC_ACK_I & any_pend) ? (NV'(1) << pend_idx) : '0;
  assign VEC_REQ_O = any_pend;
  assign VEC_IDX_O = pend_idx;

  // AXI4-Lite slave
  logic aw_hold_r;
  logic w_hold_r;
  logic [4:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic [31:0] bmask;
  logic [31:0] wbits;
  logic [31:0] w1c;
  logic wr_ctrl;
  logic wr_flag;
  logic wr_src;
  logic wr_srcen;
  logic wr_bound;
  logic wr_stat;
  logic wr_mask;
  logic wr_ok;
  assign S_AXI_AWREADY_O = ~aw_hold_r & ~bvalid_r;
  assign S_AXI_WREADY_O = ~w_hold_r & ~bvalid_r;
  assign S_AXI_ARREADY_O = ~rvalid_r;
  assign aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  assign w_take = S_AXI_WVALID_I & S_AXI_WREADY_O;
  assign ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  assign wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
  assign bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign w1c = wdata_r & bmask;
  assign wr_ctrl = wr_do & (awaddr_r == mis_pkg::OFF_CTRL);
  assign wr_flag = wr_do & (awaddr_r == mis_pkg::OFF_FLAG);
  assign wr_src = wr_do & (awaddr_r == mis_pkg::OFF_SRC);
  assign wr_srcen = wr_do & (awaddr_r == mis_pkg::OFF_SRCEN);
  assign wr_bound = wr_do & (awaddr_r == mis_pkg::OFF_BOUND);
  assign wr_stat = wr_do & (awaddr_r == mis_pkg::OFF_STAT);
  assign wr_mask = wr_do & (awaddr_r == mis_pkg::OFF_MASK);
  assign wr_ok = wr_ctrl | wr_flag | wr_src | wr_srcen | wr_bound | wr_stat | wr_mask
                 | (awaddr_r == mis_pkg::OFF_VEC);

  // Next values; hardware set wins over any clear in the same cycle
  logic [31:0] ctrl_nxt;
  logic [NV-1:0] vflag_nxt;
  logic [mis_pkg::NSRC-1:0] src_nxt;
  logic [NV-1:0] stat_nxt;
  logic [NV-1:0] vclr;
  assign wbits = (32'(ctrl_r) & ~bmask) | (wdata_r & bmask);
  // Servicing clears the global enable even against a write of one
  assign ctrl_nxt = wr_ctrl ? ((wbits & mis_pkg::CTRL_WMASK) & ~32'(|vgrant))
                            : (32'(ctrl_r) & ~32'(|vgrant));
  assign vclr = vgrant | (wr_flag ? w1c[NV-1:0] : '0);
  assign vflag_nxt = (vflag_r & ~vclr) | vset;
  // Source flags clear only by software writing ones, never by servicing
  assign src_nxt = (src_r & ~(wr_src ? w1c[mis_pkg::NSRC-1:0] : '0)) | src_ev;
  assign stat_nxt = (stat_r & ~(wr_stat ? w1c[NV-1:0] : '0)) | (vset & ~vflag_r);

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= mis_pkg::mis_ctrl_t'(mis_pkg::REG_RST);
      vflag_r <= '0;
      src_r <= '0;
      srcen_r <= mis_pkg::REG_RST;
      bound_r <= mis_pkg::REG_RST;
      stat_r <= '0;
      mask_r <= '0;
      IRQ_O <= 1'b0;
    end else begin
      ctrl_r <= mis_pkg::mis_ctrl_t'(ctrl_nxt);
      vflag_r <= vflag_nxt;
      src_r <= src_nxt;
      stat_r <= stat_nxt;
      if (wr_srcen) begin
        srcen_r <= ((srcen_r & ~bmask) | w1c) & mis_pkg::SRCEN_WMASK;
      end
      if (wr_bound) begin
        bound_r <= ((bound_r & ~bmask) | w1c) & mis_pkg::BOUND_WMASK;
      end
      if (wr_mask) begin
        mask_r <= (mask_r & ~bmask[NV-1:0]) | w1c[NV-1:0];
      end
      IRQ_O <= |(stat_nxt & mask_r);
    end
  end

  // Write channel handshake
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= mis_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {S_AXI_AWADDR_I[4:2], 2'b00};
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r <= S_AXI_WDATA_I;
        wstrb_r <= S_AXI_WSTRB_I;
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? mis_pkg::RESP_OKAY : mis_pkg::RESP_SLVERR;
      end else if (bvalid_r & S_AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID_O = bvalid_r;
  assign S_AXI_BRESP_O = bresp_r;

  // Read path
  logic [4:0] raddr;
  logic [31:0] rmux;
  logic rhit;
  assign raddr = {S_AXI_ARADDR_I[4:2], 2'b00};
  always_comb begin
    rmux = 32'h0000_0000;
    rhit = 1'b1;
    unique case (raddr)
      mis_pkg::OFF_CTRL: rmux = 32'(ctrl_r);
      mis_pkg::OFF_FLAG: rmux = 32'(vflag_r);
      mis_pkg::OFF_SRC: rmux = 32'(src_r);
      mis_pkg::OFF_SRCEN: rmux = srcen_r;
      mis_pkg::OFF_BOUND: rmux = bound_r;
      mis_pkg::OFF_STAT: rmux = 32'(stat_r);
      mis_pkg::OFF_MASK: rmux = 32'(mask_r);
      mis_pkg::OFF_VEC: rmux = 32'({STACK_FULL_I, any_pend, pend_idx});
      default: rhit = 1'b0;
    endcase
  end
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= mis_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rmux;
      rresp_r <= rhit ? mis_pkg::RESP_OKAY : mis_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end
  assign S_AXI_RVALID_O = rvalid_r;
  assign S_AXI_RDATA_O = rdata_r;
  assign S_AXI_RRESP_O = rresp_r;

endmodule : mis_irq_source

//--- pkg/mis_pkg.sv
// Constants and field layouts of the interrupt source logic.
// Assumes one system clock and an AXI4-Lite register port.
package mis_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FLAG = 5'h04;
  localparam logic [4:0] OFF_SRC = 5'h08;
  localparam logic [4:0] OFF_SRCEN = 5'h0c;
  localparam logic [4:0] OFF_BOUND = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;
  localparam logic [4:0] OFF_MASK = 5'h18;
  localparam logic [4:0] OFF_VEC = 5'h1c;

  // Writable bits and values after reset
  localparam logic [31:0] CTRL_WMASK = 32'h0000_3f7f;
  localparam logic [31:0] SRCEN_WMASK = 32'h0000_03ff;
  localparam logic [31:0] BOUND_WMASK = 32'h0fff_0fff;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // Counts of vectors and grouped sources, and the result width
  localparam int NVEC = 6;
  localparam int NSRC = 8;
  localparam int RES_W = 12;

  // Field positions
  localparam int POS_UPPER_EN = 8;
  localparam int POS_LOWER_EN = 9;
  localparam int POS_LOW_BOUND = 16;
  localparam int POS_PWM_DUTY = 5;

  // Vector indices, lower index wins
  localparam logic [2:0] VEC_EXT = 3'h0;
  localparam logic [2:0] VEC_FILT = 3'h1;
  localparam logic [2:0] VEC_CMP = 3'h2;
  localparam logic [2:0] VEC_PROT = 3'h3;
  localparam logic [2:0] VEC_GRP0 = 3'h4;
  localparam logic [2:0] VEC_GRP1 = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } mis_edge_t;

  typedef struct packed {
    logic [17:0] rsv_hi;
    mis_edge_t cmp_edge_sel;
    mis_edge_t filtered_edge_sel;
    mis_edge_t ext_pin_edge_select;
    logic rsv7;
    logic grp1_en;
    logic grp0_en;
    logic protect_req_en;
    logic cmp_req_en;
    logic filtered_req_en;
    logic ext_pin_req_en;
    logic global_irq_en;
  } mis_ctrl_t;

endpackage : mis_pkg

//--- testbench/mis_irq_source_checker.sv
// Concurrent checks on the vector port and register bus of the block.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module mis_irq_source_checker (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic STACK_FULL_I,
  input wire logic VEC_ACK_I,
  input wire logic VEC_REQ_O,
  input wire logic [2:0] VEC_IDX_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_serviced;
    VEC_REQ_O && VEC_ACK_I;
  endsequence
  // No write can land at the next edge, so no flag or enable can be cleared
  sequence s_waiting;
    VEC_REQ_O && !VEC_ACK_I && S_AXI_AWREADY_O && !S_AXI_AWVALID_I;
  endsequence
  sequence s_wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence

  a_room_gates_req: assert property (VEC_REQ_O |-> !STACK_FULL_I)
    else $error("Vector shown while the stack is full");
  a_service_blocks: assert property (s_serviced |=> !VEC_REQ_O)
    else $error("Request still shown after service");
  a_pending_holds: assert property (s_waiting |=> VEC_REQ_O || STACK_FULL_I)
    else $error("Pending request vanished without service");
  a_no_demotion: assert property (s_waiting |=> !VEC_REQ_O || VEC_IDX_O <= $past(VEC_IDX_O))
    else $error("Shown vector replaced by a lower priority one");
  a_idx_legal: assert property (VEC_REQ_O |-> VEC_IDX_O <= 3'h5)
    else $error("Vector index out of range");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID_O)
    else $error("Write response missing");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("Read data missing");
  a_write_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
    else $error("Write address taken during response");
  a_read_refused: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("Read address taken during read data");
endmodule : mis_irq_source_checker

bind mis_irq_source mis_irq_source_checker mis_irq_source_checker_inst (.*);

//--- testbench/mis_seq_model.sv
// Program sequencer stand-in: services a shown vector after a set delay.
// Assumes the block's vector port and the system clock.
`timescale 1ns/1ps
module mis_seq_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic [3:0] dly_i,
  input wire logic req_i,
  input wire logic [2:0] idx_i,
  output logic ack_o,
  output logic [2:0] idx_o,
  output logic [7:0] acks_o
);
  logic [3:0] wait_r;
  logic go;
  assign go = en_i && req_i && !ack_o;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      wait_r <= 4'h0;
      idx_o <= 3'h0;
      acks_o <= 8'h00;
    end else begin
      ack_o <= go && wait_r == dly_i;
      wait_r <= (go && wait_r != dly_i) ? wait_r + 4'h1 : 4'h0;
      // Logged only when the request still stands, as the block ignores others
      if (ack_o && req_i) begin
        idx_o <= idx_i;
        acks_o <= acks_o + 8'h01;
      end
    end
  end
endmodule : mis_seq_model

//--- testbench/mis_irq_source_tb_top.sv
// Self-checking bench for the interrupt source block.
// Assumes the package constants and the sequencer model beside it.
`timescale 1ns/1ps
module mis_irq_source_tb_top;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [9:0] en;
    logic [3:0] ev;
    logic lvl;
    logic [5:0] flag;
    logic [7:0] src;
    logic [4:0] vec;
  } mis_row_t;
  logic SYS_CLK_I = 1'b0, RSTN_I = 1'b0, STACK_FULL_I = 1'b0, seq_en = 1'b0;
  logic [4:0] S_AXI_AWADDR_I = 5'h00, S_AXI_ARADDR_I = 5'h00;
  logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, rd;
  logic [3:0] S_AXI_WSTRB_I = 4'hf, dly = 4'h0;
  logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
  logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, EXT_PIN_I = 1'b0;
  logic FILTERED_INPUT_PIN_I = 1'b0, CMP_OUT_I = 1'b0, MOTOR_PROTECT_SIGNAL_I = 1'b0;
  logic CONV_DONE_I = 1'b0, CAPTURE_OVERFLOW_I = 1'b0, CAPTURE_MATCH_I = 1'b0;
  logic PWM_PERIOD_I = 1'b0;
  logic [11:0] CONV_RESULT_I = 12'h000;
  logic [2:0] PWM_DUTY_I = 3'h0, VEC_IDX_O, got_idx;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic VEC_ACK_I, VEC_REQ_O, IRQ_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [7:0] acks;
  int fail_count = 0, total_checks = 0;
  mis_row_t rows [20] = '{
    '{16'h0100, 10'h000, 4'd0, 1'b1, 6'h01, 8'h00, 5'h00},
    '{16'h0100, 10'h000, 4'd0, 1'b0, 6'h00, 8'h00, 5'h00},
    '{16'h0200, 10'h000, 4'd0, 1'b1, 6'h00, 8'h00, 5'h00},
    '{16'h0200, 10'h000, 4'd0, 1'b0, 6'h01, 8'h00, 5'h00},
    '{16'h0000, 10'h000, 4'd0, 1'b1, 6'h00, 8'h00, 5'h00},
    '{16'h0300, 10'h000, 4'd0, 1'b0, 6'h01, 8'h00, 5'h00},
    '{16'h0400, 10'h000, 4'd1, 1'b1, 6'h02, 8'h00, 5'h00},
    '{16'h0800, 10'h000, 4'd1, 1'b0, 6'h02, 8'h00, 5'h00},
    '{16'h0c00, 10'h000, 4'd1, 1'b1, 6'h02, 8'h00, 5'h00},
    '{16'h1000, 10'h000, 4'd2, 1'b1, 6'h04, 8'h00, 5'h00},
    '{16'h2000, 10'h000, 4'd2, 1'b0, 6'h04, 8'h00, 5'h00},
    '{16'h3000, 10'h000, 4'd2, 1'b1, 6'h04, 8'h00, 5'h00},
    '{16'h0000, 10'h000, 4'd2, 1'b0, 6'h00, 8'h00, 5'h00},
    '{16'h0011, 10'h000, 4'd3, 1'b0, 6'h08, 8'h00, 5'h0b},
    '{16'h0021, 10'h103, 4'd4, 1'b1, 6'h10, 8'h03, 5'h0c},
    '{16'h0000, 10'h203, 4'd4, 1'b0, 6'h10, 8'h03, 5'h00},
    '{16'h0021, 10'h000, 4'd5, 1'b0, 6'h10, 8'h04, 5'h00},
    '{16'h0021, 10'h008, 4'd6, 1'b0, 6'h10, 8'h08, 5'h0c},
    '{16'h0041, 10'h010, 4'd7, 1'b0, 6'h20, 8'h10, 5'h0d},
    '{16'h0000, 10'h080, 4'd8, 1'b0, 6'h20, 8'h80, 5'h00}};

  always #25 SYS_CLK_I = ~SYS_CLK_I;

  mis_irq_source mis_irq_source_inst (.*);
  mis_seq_model mis_seq_model_inst (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .en_i(seq_en),
    .dly_i(dly), .req_i(VEC_REQ_O), .idx_i(VEC_IDX_O), .ack_o(VEC_ACK_I), .idx_o(got_idx),
    .acks_o(acks));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready is looked at on the falling edge, where it already stands as the next
  // rising edge sees it, so the result never races the design
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    int n;
    logic pa, pw, pb, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    n = 0;
    @(posedge SYS_CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    while ((pa || pw || pb) && n < 60) begin
      @(negedge SYS_CLK_I);
      ta = pa && S_AXI_AWREADY_O;
      tw = pw && S_AXI_WREADY_O;
      if (pb && S_AXI_BVALID_O) begin
        pb = 1'b0;
        chk({30'h0, S_AXI_BRESP_O}, {30'h0, mis_pkg::RESP_OKAY});
      end
      @(posedge SYS_CLK_I);
      if (ta) S_AXI_AWVALID_I <= 1'b0;
      if (tw) S_AXI_WVALID_I <= 1'b0;
      if (!pb) S_AXI_BREADY_I <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      n++;
    end
    if (pa || pw || pb) begin
      fail_count++;
      $display("mismatch at %0t: write not answered", $time);
      finish_test();
    end
  endtask : axw

  task automatic axr(input logic [4:0] a);
    int n;
    logic pa, ta, t;
    pa = 1'b1;
    n = 0;
    t = 1'b0;
    @(posedge SYS_CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    while (!t && n < 60) begin
      @(negedge SYS_CLK_I);
      ta = pa && S_AXI_ARREADY_O;
      t = S_AXI_RVALID_O;
      if (t) begin
        rd = S_AXI_RDATA_O;
        chk({30'h0, S_AXI_RRESP_O}, {30'h0, mis_pkg::RESP_OKAY});
      end
      @(posedge SYS_CLK_I);
      if (ta) S_AXI_ARVALID_I <= 1'b0;
      if (t) S_AXI_RREADY_I <= 1'b0;
      pa = pa && !ta;
      n++;
    end
    if (!t) begin
      fail_count++;
      $display("mismatch at %0t: read not answered", $time);
      finish_test();
    end
  endtask : axr

  task automatic fire(input logic [3:0] e, input logic l);
    @(posedge SYS_CLK_I);
    case (e)
      4'd0: EXT_PIN_I <= l;
      4'd1: FILTERED_INPUT_PIN_I <= l;
      4'd2: CMP_OUT_I <= l;
      4'd3: MOTOR_PROTECT_SIGNAL_I <= 1'b1;
      4'd4: CONV_DONE_I <= 1'b1;
      4'd5: CAPTURE_OVERFLOW_I <= 1'b1;
      4'd6: CAPTURE_MATCH_I <= 1'b1;
      4'd7: PWM_PERIOD_I <= 1'b1;
      4'd8: PWM_DUTY_I <= 3'h4;
      default: {CMP_OUT_I, MOTOR_PROTECT_SIGNAL_I, CAPTURE_MATCH_I} <= 3'h7;
    endcase
    CONV_RESULT_I <= l ? 12'h900 : 12'h080;
    @(posedge SYS_CLK_I);
    {MOTOR_PROTECT_SIGNAL_I, CONV_DONE_I, CAPTURE_OVERFLOW_I, CAPTURE_MATCH_I} <= 4'h0;
    PWM_PERIOD_I <= 1'b0;
    PWM_DUTY_I <= 3'h0;
    // Pins pass a three-flop synchroniser before their edge is seen
    repeat (5) @(posedge SYS_CLK_I);
  endtask : fire

  initial begin
    repeat (8) @(posedge SYS_CLK_I);
    RSTN_I <= 1'b1;
    repeat (3) @(posedge SYS_CLK_I);
    axw(mis_pkg::OFF_BOUND, 32'h0100_0800);
    foreach (rows[i]) begin
      axw(mis_pkg::OFF_CTRL, {16'h0, rows[i].ctrl});
      axw(mis_pkg::OFF_FLAG, 32'h3f);
      axw(mis_pkg::OFF_SRC, 32'hff);
      axw(mis_pkg::OFF_SRCEN, {22'h0, rows[i].en});
      fire(rows[i].ev, rows[i].lvl);
      axr(mis_pkg::OFF_FLAG);
      chk(rd, {26'h0, rows[i].flag});
      axr(mis_pkg::OFF_SRC);
      chk(rd, {24'h0, rows[i].src});
      axr(mis_pkg::OFF_VEC);
      chk(rd & (rows[i].vec[3] ? 32'h1f : 32'h18), {27'h0, rows[i].vec});
      $display("row %0d done", i);
    end
    // Three requests at once behind a full stack, then served one by one
    STACK_FULL_I <= 1'b1;
    axw(mis_pkg::OFF_SRCEN, 32'h008);
    axw(mis_pkg::OFF_CTRL, 32'h1039);
    // Flags left over from the last row would spoil the final reads
    axw(mis_pkg::OFF_FLAG, 32'h3f);
    axw(mis_pkg::OFF_SRC, 32'hff);
    axw(mis_pkg::OFF_STAT, 32'h3f);
    fire(4'd9, 1'b1);
    axr(mis_pkg::OFF_VEC);
    chk(rd & 32'h18, 32'h10);
    seq_en <= 1'b1;
    STACK_FULL_I <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (k > 0) axw(mis_pkg::OFF_CTRL, 32'h1039);
      for (int t = 0; t < 40 && acks !== 8'(k + 1); t++) @(negedge SYS_CLK_I);
      chk({24'h0, acks}, k + 1);
      chk({29'h0, got_idx}, 32'(2 + k));
      axr(mis_pkg::OFF_CTRL);
      chk(rd, 32'h1038);
      dly <= dly + 4'h3;
    end
    axr(mis_pkg::OFF_FLAG);
    chk(rd, 32'h0);
    axr(mis_pkg::OFF_SRC);
    chk(rd, 32'h08);
    $display("service order test done");
    axw(mis_pkg::OFF_MASK, 32'h04);
    repeat (2) @(negedge SYS_CLK_I);
    chk({31'h0, IRQ_O}, 32'h1);
    axw(mis_pkg::OFF_STAT, 32'h3f);
    repeat (2) @(negedge SYS_CLK_I);
    chk({31'h0, IRQ_O}, 32'h0);
    $display("interrupt output test done");
    @(posedge SYS_CLK_I);
    RSTN_I <= 1'b0;
    seq_en <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    RSTN_I <= 1'b1;
    repeat (3) @(posedge SYS_CLK_I);
    for (int o = 0; o < 7; o++) begin
      axr(5'(o * 4));
      chk(rd, mis_pkg::REG_RST);
    end
    axw(mis_pkg::OFF_CTRL, 32'hffff_ffff);
    axr(mis_pkg::OFF_CTRL);
    chk(rd, mis_pkg::CTRL_WMASK);
    $display("reset test done");
    finish_test();
  end
endmodule : mis_irq_source_tb_top
